// file: common/bzsg_pkg.sv
// bzsg_pkg: constants shared by the buzzer sound generator files
// assumes a 100 MHz system clock and an AXI4-Lite register port
package bzsg_pkg;

  // ==========================================================
  // register map (word indices; byte address bits 17:0 decoded, bits 31:18 must be 0)
  localparam logic [15:0] BUZZER_CONTROL_OFS      = 16'hff44;
  localparam logic [15:0] TONE_FREQUENCY_DUTY_OFS = 16'hff45;
  // the printed offsets are not word multiples, so byte address = index * 4
  localparam logic [17:0] BUZZER_CONTROL_ADDR     = {BUZZER_CONTROL_OFS, 2'b00};
  localparam logic [17:0] TONE_FREQUENCY_DUTY_ADDR = {TONE_FREQUENCY_DUTY_OFS, 2'b00};

  // ==========================================================
  // control register field positions
  localparam int TONE_ON_BIT        = 0;
  localparam int ENV_ON_BIT         = 1;
  localparam int ENV_RESTART_BIT    = 2;
  localparam int ENV_TIME_BIT       = 3;
  localparam int ONESHOT_WIDTH_BIT  = 4;
  localparam int ONESHOT_TRIG_BIT   = 5;
  localparam int ONESHOT_STOP_BIT   = 6;
  // frequency/duty register field positions
  localparam int FREQ_LSB           = 0;
  localparam int DUTY_LSB           = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] FREQDUTY_RESET = 8'h00;

  // ==========================================================
  // timing: base tick 65536 Hz gives 4096 Hz at 16 counts per period
  localparam int CLOCK_HZ        = 100_000_000;
  localparam int BASE_HZ         = 65536;
  localparam int BASE_DIV        = CLOCK_HZ / BASE_HZ;       // rounded down
  localparam int ONESHOT_LONG_US = 125_000;                  // 125 msec
  localparam int ONESHOT_SHORT_NS = 31_250_000;              // 31.25 msec
  localparam int ENV_LONG_MS     = 1000;                     // 1 sec
  localparam int ENV_SHORT_MS    = 500;                      // 0.5 sec
  localparam int ONESHOT_LONG_CYC  = ONESHOT_LONG_US * (CLOCK_HZ / 1_000_000);
  localparam int ONESHOT_SHORT_CYC = ONESHOT_SHORT_NS / (1_000_000_000 / CLOCK_HZ);
  localparam int ENV_LONG_CYC    = ENV_LONG_MS * (CLOCK_HZ / 1000);
  localparam int ENV_SHORT_CYC   = ENV_SHORT_MS * (CLOCK_HZ / 1000);
  localparam int ENV_STEPS       = 8;                        // envelope levels

  // ==========================================================
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: verilog/bzsg_tone.sv
// bzsg_tone: square wave of 16/20/24/28 base ticks with programmable high count
// assumes a one-cycle base tick pulse from the parent on the same clock
`timescale 1ns/10ps
module bzsg_tone (
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] freq_in,
  input  wire logic [2:0] duty_in,
  output logic            wave_out
);
  import bzsg_pkg::*;

  logic [4:0] phase;
  logic [4:0] period;
  logic [4:0] high_cnt;

  // ==========================================================
  // period and high count per frequency code
  always_comb begin
    unique case (freq_in[1:0])
      2'b00:   period = 5'd16;
      2'b01:   period = 5'd20;
      2'b10:   period = 5'd24;
      default: period = 5'd28;
    endcase
    // short periods start at 8, long ones at 12, each code step removes one
    high_cnt = (freq_in[1] ? 5'd12 : 5'd8) - {2'b00, duty_in};
  end

  // ==========================================================
  // phase counter; frequency bit 2 halves the tick rate outside
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase    <= 5'd0;
      wave_out <= 1'b0;
    end else if (tick_in) begin
      phase    <= (phase >= period - 5'd1) ? 5'd0 : phase + 5'd1;
      wave_out <= (phase < high_cnt);
    end
  end
endmodule

// file: verilog/bzsg_env.sv
// bzsg_env: decaying digital envelope, steps a level down over the decay time
// assumes a restart pulse and an enable level from the parent on the same clock
`timescale 1ns/10ps
module bzsg_env #(
  parameter int STEP_LONG  = bzsg_pkg::ENV_LONG_CYC / bzsg_pkg::ENV_STEPS,
  parameter int STEP_SHORT = bzsg_pkg::ENV_SHORT_CYC / bzsg_pkg::ENV_STEPS
) (
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  input  wire logic       run_in,
  input  wire logic       restart_in,
  input  wire logic       long_in,
  output logic [2:0]      level_out
);
  import bzsg_pkg::*;

  initial begin
    if (STEP_LONG < 1 || STEP_SHORT < 1) $error("envelope step too short");
  end

  logic [27:0] step_cnt;
  logic [27:0] step_len;

  assign step_len = long_in ? 28'(STEP_LONG) : 28'(STEP_SHORT);

  // ==========================================================
  // level falls from full to silent; restart or idle reloads full level
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_cnt  <= 28'd0;
      level_out <= 3'h7;
    end else if (!run_in || restart_in) begin
      step_cnt  <= 28'd0;
      level_out <= 3'h7;
    end else if (level_out != 3'h0) begin
      if (step_cnt >= step_len - 28'd1) begin
        step_cnt  <= 28'd0;
        level_out <= level_out - 3'h1;
      end else begin
        step_cnt <= step_cnt + 28'd1;
      end
    end
  end
endmodule

// file: verilog/bzsg_top.sv
// bzsg_top: buzzer sound generator with AXI4-Lite register port
// What this block does
// - three-bit frequency code picks one of eight tones, 4096.0 down to 1170.3 Hz
// - three-bit duty code lowers the high count by one per step
// - tone-on bit gates the continuous tone onto the buzzer, resets to 0
// - envelope enable bit applies a decaying envelope, resets to 0
// - attenuation bit picks 1 sec decay when set, 0.5 sec when clear
// - writing 1 to envelope restart begins the decay again; reads as 0
// - envelope enable is cleared while a one-shot burst plays
// - writing 1 to trigger starts a burst; reading shows busy
// - width bit picks 125 msec or 31.25 msec bursts, then status is ready
// - writing 1 to force stop ends a burst at once
// - buzzer reaches the shared pin only while its port data bit is 1
// assumes a single 100 MHz clock; the shared pin data bit is a plain input
`timescale 1ns/10ps
module bzsg_top #(
  parameter int ONESHOT_LONG  = bzsg_pkg::ONESHOT_LONG_CYC,
  parameter int ONESHOT_SHORT = bzsg_pkg::ONESHOT_SHORT_CYC,
  parameter int BASE_DIVIDE   = bzsg_pkg::BASE_DIV,
  parameter int ENV_STEP_LONG  = bzsg_pkg::ENV_LONG_CYC / bzsg_pkg::ENV_STEPS,
  parameter int ENV_STEP_SHORT = bzsg_pkg::ENV_SHORT_CYC / bzsg_pkg::ENV_STEPS
) (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // shared pin: port data register bit from the dc output port
  input  wire logic        shared_dc_output_pin_data_in,
  output logic             shared_dc_output_pin_out,
  output logic             oneshot_busy_out
);
  import bzsg_pkg::*;

  initial begin
    if (ONESHOT_LONG < 2 || ONESHOT_SHORT < 2 || BASE_DIVIDE < 2)
      $error("bzsg_top: counts too small");
  end

  // ==========================================================
  // register state
  logic       tone_on;
  logic       env_on;
  logic       env_long;
  logic       oneshot_width_select;
  logic [2:0] duty_sel;
  logic [2:0] tone_freq;
  logic       oneshot_active;
  logic [26:0] oneshot_cnt;

  // ==========================================================
  // address decode shared by read and write paths
  function automatic logic [1:0] reg_decode(input logic [31:0] addr);
    if (addr[17:0] == BUZZER_CONTROL_ADDR)
      reg_decode = 2'b01;
    else if (addr[17:0] == TONE_FREQUENCY_DUTY_ADDR && addr[31:18] == 14'h0000)
      reg_decode = 2'b10;
    else
      reg_decode = 2'b00;
    if (addr[31:18] != 14'h0000)
      reg_decode = 2'b00;
  endfunction

  // ==========================================================
  // write channel: hold address and data until both have arrived
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        wr_fire;
  logic [1:0]  wr_sel;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_sel  = reg_decode(aw_addr);

  // address and data are taken in either order, one each per write
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 32'h0000_0000;
      w_data            <= 32'h0000_0000;
      w_lane0           <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !s_axi_awready_out;
      s_axi_wready_out  <= !w_held && !s_axi_wready_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata_in;
        w_lane0 <= s_axi_wstrb_in[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response follows one cycle after both halves are in
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (wr_sel == 2'b00) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // strobes only act when byte lane 0 carries the data
  logic ctl_wr;
  logic fd_wr;
  assign ctl_wr = wr_fire && wr_sel == 2'b01 && w_lane0;
  assign fd_wr  = wr_fire && wr_sel == 2'b10 && w_lane0;

  logic trig_pulse;
  logic stop_pulse;
  logic restart_pulse;
  assign trig_pulse    = ctl_wr && w_data[ONESHOT_TRIG_BIT];
  assign stop_pulse    = ctl_wr && w_data[ONESHOT_STOP_BIT];
  assign restart_pulse = ctl_wr && w_data[ENV_RESTART_BIT];

  // ==========================================================
  // control bits written by software
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tone_on              <= CONTROL_RESET[TONE_ON_BIT];
      env_long             <= CONTROL_RESET[ENV_TIME_BIT];
      oneshot_width_select <= CONTROL_RESET[ONESHOT_WIDTH_BIT];
    end else if (ctl_wr) begin
      tone_on              <= w_data[TONE_ON_BIT];
      env_long             <= w_data[ENV_TIME_BIT];
      oneshot_width_select <= w_data[ONESHOT_WIDTH_BIT];
    end
  end

  // envelope enable is held at 0 for as long as a burst plays
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      env_on <= CONTROL_RESET[ENV_ON_BIT];
    end else if (oneshot_active || trig_pulse) begin
      env_on <= 1'b0;
    end else if (ctl_wr) begin
      env_on <= w_data[ENV_ON_BIT];
    end
  end

  // frequency and duty register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tone_freq <= FREQDUTY_RESET[FREQ_LSB +: 3];
      duty_sel  <= FREQDUTY_RESET[DUTY_LSB +: 3];
    end else if (fd_wr) begin
      tone_freq <= w_data[FREQ_LSB +: 3];
      duty_sel  <= w_data[DUTY_LSB +: 3];
    end
  end

  // ==========================================================
  // one-shot burst timer; stop wins over a trigger in the same write
  // a width written together with the trigger already applies to that burst
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oneshot_active <= 1'b0;
      oneshot_cnt    <= 27'd0;
    end else if (stop_pulse) begin
      oneshot_active <= 1'b0;
      oneshot_cnt    <= 27'd0;
    end else if (trig_pulse) begin
      oneshot_active <= 1'b1;
      oneshot_cnt    <= w_data[ONESHOT_WIDTH_BIT] ? 27'(ONESHOT_LONG - 1)
                                                  : 27'(ONESHOT_SHORT - 1);
    end else if (oneshot_active) begin
      if (oneshot_cnt == 27'd0)
        oneshot_active <= 1'b0;
      else
        oneshot_cnt <= oneshot_cnt - 27'd1;
    end
  end

  // ==========================================================
  // read channel: one read at a time, answer the cycle after acceptance
  logic [7:0] ctl_rd;
  logic [7:0] fd_rd;
  assign ctl_rd = {1'b0, 1'b0, oneshot_active, oneshot_width_select,
                   env_long, 1'b0, env_on, tone_on};
  assign fd_rd  = {1'b0, duty_sel, 1'b0, tone_freq};

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out
                           && !s_axi_arvalid_in ? 1'b1
                           : (!s_axi_rvalid_out && !s_axi_arready_out);
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        unique case (reg_decode(s_axi_araddr_in))
          2'b01: begin
            s_axi_rdata_out <= {24'h00_0000, ctl_rd};
            s_axi_rresp_out <= RESP_OKAY;
          end
          2'b10: begin
            s_axi_rdata_out <= {24'h00_0000, fd_rd};
            s_axi_rresp_out <= RESP_OKAY;
          end
          default: begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // base tick; bit 2 of the frequency code halves it for the low octave
  logic [15:0] div_cnt;
  logic        base_tick;
  logic        half_toggle;
  logic        tone_tick;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt     <= 16'h0000;
      base_tick   <= 1'b0;
      half_toggle <= 1'b0;
    end else begin
      base_tick <= (div_cnt == 16'h0000);
      div_cnt   <= (div_cnt == 16'h0000) ? 16'(BASE_DIVIDE - 1) : div_cnt - 16'h0001;
      if (base_tick)
        half_toggle <= !half_toggle;
    end
  end

  assign tone_tick = base_tick && (!tone_freq[2] || half_toggle);

  logic       wave;
  logic [2:0] env_level;

  bzsg_tone u_tone (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tick_in  (tone_tick),
    .freq_in  (tone_freq),
    .duty_in  (duty_sel),
    .wave_out (wave)
  );

  bzsg_env #(
    .STEP_LONG  (ENV_STEP_LONG),
    .STEP_SHORT (ENV_STEP_SHORT)
  ) u_env (
    .clock_in   (clock_in),
    .rstn_in    (rstn_in),
    .run_in     (env_on && tone_on),
    .restart_in (restart_pulse),
    .long_in    (env_long),
    .level_out  (env_level)
  );

  // ==========================================================
  // envelope as gating: pwm of tone over eight slots by level
  logic [2:0] env_slot;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in)
      env_slot <= 3'h0;
    else
      env_slot <= env_slot + 3'h1;
  end

  // shared pin data bit passes two flops; the pin drives low when not buzzing
  logic pin_sync1;
  logic pin_sync2;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= shared_dc_output_pin_data_in;
      pin_sync2 <= pin_sync1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shared_dc_output_pin_out <= 1'b0;
      oneshot_busy_out         <= 1'b0;
    end else begin
      shared_dc_output_pin_out <= pin_sync2 && wave
                                  && (tone_on || oneshot_active)
                                  && (!env_on || env_slot < env_level);
      oneshot_busy_out         <= oneshot_active;
    end
  end
endmodule

// file: sim/bzsg_top_asserts.sv
// bzsg_top_asserts: port-level checks of the buzzer sound generator
// assumes a bind onto bzsg_top; sees only its ports
`timescale 1ns/10ps
module bzsg_top_asserts #(
  parameter int ONESHOT_LONG = 200
) (
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic        s_axi_awready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        shared_dc_output_pin_data_in,
  input wire logic        shared_dc_output_pin_out,
  input wire logic        oneshot_busy_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  int busy_run;
  // ==========================================================
  // burst length counter: a status stuck at busy shows up here
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in)
      busy_run <= 0;
    else
      busy_run <= oneshot_busy_out ? busy_run + 1 : 0;
  end
  // ==========================================================
  // bus handshakes, pin behaviour and burst length
  property p_rhold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rzero; s_axi_rvalid_out |-> s_axi_rdata_out[31:7] == 25'h0; endproperty
  a_rzero: assert property (p_rzero) else $error("unused read bits set");
  property p_rresp; s_axi_rvalid_out |-> s_axi_rresp_out inside {2'b00, 2'b10}; endproperty
  a_rresp: assert property (p_rresp) else $error("bad read response");
  property p_awpulse; s_axi_awready_out |=> !s_axi_awready_out; endproperty
  a_awpulse: assert property (p_awpulse) else $error("awready held two cycles");
  property p_bblock; s_axi_bvalid_out |-> !s_axi_awready_out; endproperty
  a_bblock: assert property (p_bblock) else $error("address taken while answer pending");
  property p_pin; !shared_dc_output_pin_data_in [*4] |-> !shared_dc_output_pin_out; endproperty
  a_pin: assert property (p_pin) else $error("tone on pin while port bit low");
  property p_busy; busy_run <= ONESHOT_LONG + 4; endproperty
  a_busy: assert property (p_busy) else $error("burst too long");
endmodule

// file: sim/bzsg_buzzer_model.sv
// bzsg_buzzer_model: piezo buzzer on the shared pin, measures what it hears
// assumes the pin is sampled on the system clock
`timescale 1ns/10ps
module bzsg_buzzer_model (
  input  wire logic clock_in,
  input  wire logic pin_in,
  input  wire logic clr_in,
  output int        period_out,
  output int        high_out,
  output int        hi_cnt_out
);
  logic last = 1'b0;
  int   age  = 0;
  // a rising edge closes a period, a falling edge a high phase
  always_ff @(posedge clock_in) begin
    last <= pin_in;
    age <= (pin_in && !last) ? 1 : age + 1;
    if (pin_in && !last) period_out <= age;
    if (!pin_in && last) high_out <= age;
    hi_cnt_out <= clr_in ? 0 : hi_cnt_out + int'(pin_in); // loudness in a window
  end
endmodule

// file: sim/bzsg_tb_top.sv
// bzsg_tb_top: self-checking bench for the buzzer sound generator
// assumes package, design, buzzer model and checker compiled before it
`timescale 1ns/10ps
module bzsg_tb_top;
  import bzsg_pkg::*;
  localparam int LONG = 200;
  localparam int SHORT = 50;
  localparam int BD = 4;
  localparam logic [31:0] CA = {14'h0, BUZZER_CONTROL_ADDR};
  localparam logic [31:0] FA = {14'h0, TONE_FREQUENCY_DUTY_ADDR};
  logic        clock_in = 1'b0, rstn = 1'b0, pin_data = 1'b1, clr = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin, busy;
  logic [1:0]  bresp, rresp;
  int          period, high, hits, err_count = 0, comparisons = 0;
  always #5 clock_in = ~clock_in;
  bzsg_top #(.ONESHOT_LONG(LONG), .ONESHOT_SHORT(SHORT), .BASE_DIVIDE(BD),
    .ENV_STEP_LONG(80), .ENV_STEP_SHORT(40)) dut (
    .clock_in(clock_in), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .shared_dc_output_pin_data_in(pin_data),
    .shared_dc_output_pin_out(pin), .oneshot_busy_out(busy));
  bzsg_buzzer_model u_bz (.clock_in(clock_in), .pin_in(pin), .clr_in(clr),
    .period_out(period), .high_out(high), .hi_cnt_out(hits));
  // ==========================================================
  // reporting and bus tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a bounded wait that ran out ends the run
  task automatic lim(input int i, input int n);
    if (i >= n) begin
      err_count++;
      finish_test();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock_in);
      if (bvalid === 1'b1) break;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    lim(i, 50);
  endtask
  // read: slow delays rready so the slave must hold its answer
  task automatic rdc(input logic [31:0] a, input int slow, input logic [7:0] ed,
                     input logic [1:0] er);
    int i;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge clock_in);
      if (rready && rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (!arvalid && i >= slow) rready <= 1'b1;
    end
    rready <= 1'b0;
    chk("rdata", rdata, {24'h0, ed});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    lim(i, 60);
  endtask
  // clears the loudness count, then listens n cycles
  task automatic win(input int n);
    @(posedge clock_in);
    clr <= 1'b1;
    @(posedge clock_in);
    clr <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask
  // ==========================================================
  // scenarios
  task automatic sc_reset();
    rdc(CA, 4, 8'h00, RESP_OKAY);
    rdc(FA, 0, 8'h00, RESP_OKAY);
    rdc(32'h100, 0, 8'h00, RESP_SLVERR);
    wr(32'h100, 8'h01, RESP_SLVERR);
    wr(FA, 8'hff, RESP_OKAY);
    rdc(FA, 0, 8'h77, RESP_OKAY);
    rdc(CA, 0, 8'h00, RESP_OKAY);
  endtask
  // every frequency code, each with the duty code of the same number
  task automatic sc_tone();
    int f;
    int m;
    wr(CA, 8'h01, RESP_OKAY);
    for (f = 0; f < 8; f++) begin
      m = (f > 3) ? 2 * BD : BD;
      wr(FA, 8'(f * 17), RESP_OKAY);
      repeat (700) @(posedge clock_in);
      chk("period", period, (16 + 4 * (f % 4)) * m);
      chk("high", high, (((f % 4) < 2 ? 8 : 12) - f) * m);
    end
  endtask
  task automatic sc_gate();
    pin_data <= 1'b0;
    // the port bit needs two sync flops and the output flop to reach the pin
    repeat (3) @(posedge clock_in);
    win(300);
    chk("gated", hits, 0);
    pin_data <= 1'b1;
    wr(CA, 8'h00, RESP_OKAY);
    win(300);
    chk("tone off", hits, 0);
  endtask
  task automatic sc_env();
    wr(FA, 8'h00, RESP_OKAY);
    wr(CA, 8'h07, RESP_OKAY);
    rdc(CA, 0, 8'h03, RESP_OKAY);
    repeat (400) @(posedge clock_in);
    win(128);
    chk("short decay", hits, 0);
    wr(CA, 8'h0f, RESP_OKAY);
    repeat (400) @(posedge clock_in);
    win(128);
    chk("long decay", hits != 0, 1);
    repeat (300) @(posedge clock_in);
    win(128);
    chk("decayed", hits, 0);
    wr(CA, 8'h0f, RESP_OKAY);
    win(128);
    chk("restart", hits != 0, 1);
  endtask
  task automatic sc_shot();
    int w;
    int n;
    for (w = 0; w < 2; w++) begin
      wr(CA, 8'h02, RESP_OKAY);
      wr(CA, 8'(8'h22 | (w << 4)), RESP_OKAY);
      rdc(CA, 0, 8'(8'h20 | (w << 4)), RESP_OKAY);
      for (n = 0; n < 400 && busy === 1'b1; n++) @(posedge clock_in);
      chk("burst", n > (w ? LONG : SHORT) - 20 && n <= (w ? LONG : SHORT), 1);
      rdc(CA, 0, 8'(w << 4), RESP_OKAY);
    end
  endtask
  task automatic sc_stop();
    int n;
    wr(CA, 8'h30, RESP_OKAY);
    repeat (20) @(posedge clock_in);
    wr(CA, 8'h50, RESP_OKAY);
    for (n = 0; n < 8 && busy !== 1'b0; n++) @(posedge clock_in);
    chk("stopped", n < 3, 1);
    rdc(CA, 0, 8'h10, RESP_OKAY);
    wr(CA, 8'h60, RESP_OKAY);
    rdc(CA, 0, 8'h00, RESP_OKAY);
    wr(CA, 8'h31, RESP_OKAY);
    rstn <= 1'b0;
    repeat (3) @(posedge clock_in);
    rstn <= 1'b1;
    chk("busy reset", busy, 0);
    rdc(CA, 0, 8'h00, RESP_OKAY);
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rstn <= 1'b1;
    sc_reset();
    sc_tone();
    sc_gate();
    sc_env();
    sc_shot();
    sc_stop();
    finish_test();
  end
endmodule
bind bzsg_top bzsg_top_asserts #(.ONESHOT_LONG(ONESHOT_LONG)) u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in),
  .shared_dc_output_pin_data_in(shared_dc_output_pin_data_in),
  .shared_dc_output_pin_out(shared_dc_output_pin_out), .oneshot_busy_out(oneshot_busy_out));
